// file: include/event_capture_timer_defs.vh
// Constants for the event capture timer: offsets, fields, resets, counts.
// Assumes a 32-bit classic Wishbone slave decoding full byte addresses.
`ifndef EVENT_CAPTURE_TIMER_DEFS_VH
`define EVENT_CAPTURE_TIMER_DEFS_VH

`define ADR_RELOAD 32'hffff0380
`define ADR_COUNT 32'hffff0384
`define ADR_CONTROL 32'hffff0388
`define ADR_IRQ_CLEAR 32'hffff038c
`define ADR_SNAPSHOT 32'hffff0390
`define ADR_STATUS 32'hffff0394
`define ADR_MASK 32'hffff0398

`define CTL_PRE_LSB 0
`define CTL_PRE_MSB 3
`define CTL_PERIODIC 6
`define CTL_ENABLE 7
`define CTL_UP 8
`define CTL_CLKSEL 9
`define CTL_SRC_LSB 12
`define CTL_SRC_MSB 16
`define CTL_CAP_EN 17
`define CTL_WMASK 32'h0003f3cf

`define PRE_DIV1 4'h0
`define PRE_DIV16 4'h4
`define PRE_DIV256 4'h8
`define PRE_DIV32768 4'hf
`define LIM_DIV1 15'h0000
`define LIM_DIV16 15'h000f
`define LIM_DIV256 15'h00ff
`define LIM_DIV32768 15'h7fff

`define RST_RELOAD 16'h0000
`define RST_COUNT 16'hffff
`define RST_CONTROL 32'h00000000
`define RST_SNAPSHOT 16'h0000
`define CNT_MIN 16'h0000
`define CNT_MAX 16'hffff

`define NUM_SRC 18
`define SRC_LAST 5'h11

`define ST_TIMEOUT 0
`define ST_CAPTURE 1
`define ST_WIDTH 2

`endif

// file: rtl/event_capture_timer.v
// General event counter: 16-bit up/down timer, prescaler, event snapshot.
// Assumes a classic Wishbone master and inputs synchronous to clk_i.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`include "event_capture_timer_defs.vh"

module event_capture_timer (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire lp_osc_i,
    input wire [17:0] irq_src_i,
    output reg irq_o,
    output reg tick_o
);

reg [15:0] reload_value;
reg [15:0] live_count;
reg [31:0] control;
reg [15:0] snapshot;
wire [1:0] status;
reg [1:0] mask;
reg [14:0] pre_count;
wire lp_edge;
wire [17:0] src_edges;
wire [31:0] ctl_merged;
wire [15:0] rel_merged;

reg [14:0] pre_limit;
reg [31:0] next_rdata;
reg [31:0] next_control;
reg [15:0] next_reload;
reg [15:0] next_count;

wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr = access & wb_we_i;
wire rd_hit = access & ~wb_we_i;
wire wr_reload = wr & (wb_adr_i == `ADR_RELOAD);
wire wr_control = wr & (wb_adr_i == `ADR_CONTROL);
wire wr_clear = wr & (wb_adr_i == `ADR_IRQ_CLEAR);
wire wr_status = wr & (wb_adr_i == `ADR_STATUS) & wb_sel_i[0];
wire wr_mask = wr & (wb_adr_i == `ADR_MASK) & wb_sel_i[0];

wire [3:0] pre_sel = control[`CTL_PRE_MSB:`CTL_PRE_LSB];
wire [4:0] src_sel = control[`CTL_SRC_MSB:`CTL_SRC_LSB];
wire count_up = control[`CTL_UP];
wire periodic = control[`CTL_PERIODIC];
wire enable = control[`CTL_ENABLE];

// Oscillator edge as an enable; core clock source ticks every cycle
// Oscillator is slow against clk_i, so one edge gives exactly one tick
rise_detect #(
    .WIDTH(1)
) i_lp_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(lp_osc_i),
    .rise_o(lp_edge)
);

wire src_tick = control[`CTL_CLKSEL] ? lp_edge : 1'b1;

wire step = enable & src_tick & (pre_count == pre_limit);
wire at_end = count_up ? (live_count == `CNT_MAX) : (live_count == `CNT_MIN);
wire terminal = step & at_end;

// Edges found on every line, so a selector change cannot fake one
rise_detect #(
    .WIDTH(18)
) i_src_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(irq_src_i),
    .rise_o(src_edges)
);

// Out-of-range selections never capture
wire src_valid = (src_sel <= `SRC_LAST);
wire src_rise = src_valid & src_edges[src_sel];
wire capture = control[`CTL_CAP_EN] & src_rise;

// Unlisted codes fall back to divide by one
always @* begin
    case (pre_sel)
        `PRE_DIV1: pre_limit = `LIM_DIV1;
        `PRE_DIV16: pre_limit = `LIM_DIV16;
        `PRE_DIV256: pre_limit = `LIM_DIV256;
        `PRE_DIV32768: pre_limit = `LIM_DIV32768;
        default: pre_limit = `LIM_DIV1;
    endcase
end

// Byte enables honoured per lane; untouched lanes keep their old value
byte_lane #(
    .WIDTH(8)
) i_ctl_b0 (
    .sel_i(wb_sel_i[0]),
    .old_i(control[7:0]),
    .new_i(wb_dat_i[7:0]),
    .merged_o(ctl_merged[7:0])
);

byte_lane #(
    .WIDTH(8)
) i_ctl_b1 (
    .sel_i(wb_sel_i[1]),
    .old_i(control[15:8]),
    .new_i(wb_dat_i[15:8]),
    .merged_o(ctl_merged[15:8])
);

byte_lane #(
    .WIDTH(8)
) i_ctl_b2 (
    .sel_i(wb_sel_i[2]),
    .old_i(control[23:16]),
    .new_i(wb_dat_i[23:16]),
    .merged_o(ctl_merged[23:16])
);

byte_lane #(
    .WIDTH(8)
) i_ctl_b3 (
    .sel_i(wb_sel_i[3]),
    .old_i(control[31:24]),
    .new_i(wb_dat_i[31:24]),
    .merged_o(ctl_merged[31:24])
);

byte_lane #(
    .WIDTH(8)
) i_rel_b0 (
    .sel_i(wb_sel_i[0]),
    .old_i(reload_value[7:0]),
    .new_i(wb_dat_i[7:0]),
    .merged_o(rel_merged[7:0])
);

byte_lane #(
    .WIDTH(8)
) i_rel_b1 (
    .sel_i(wb_sel_i[1]),
    .old_i(reload_value[15:8]),
    .new_i(wb_dat_i[15:8]),
    .merged_o(rel_merged[15:8])
);

// Reserved control bits read zero whatever is written
always @* begin
    next_control = ctl_merged & `CTL_WMASK;
end

always @* begin
    next_reload = rel_merged;
end

// Counter step: reload in periodic mode, wrap when free-running
always @* begin
    next_count = live_count;
    if (step) begin
        if (at_end) begin
            if (periodic) begin
                next_count = reload_value;
            end else if (count_up) begin
                next_count = `CNT_MIN;
            end else begin
                next_count = `CNT_MAX;
            end
        end else if (count_up) begin
            next_count = live_count + 16'h0001;
        end else begin
            next_count = live_count - 16'h0001;
        end
    end
end

always @* begin
    case (wb_adr_i)
        `ADR_RELOAD: next_rdata = {16'h0000, reload_value};
        `ADR_COUNT: next_rdata = {16'h0000, live_count};
        `ADR_CONTROL: next_rdata = control;
        `ADR_SNAPSHOT: next_rdata = {16'h0000, snapshot};
        `ADR_STATUS: next_rdata = {30'h00000000, status};
        `ADR_MASK: next_rdata = {30'h00000000, mask};
        default: next_rdata = 32'h00000000;
    endcase
end

// Bus slave: one wait-free ack per request, unmapped reads return zero
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= access;
        if (rd_hit) begin
            wb_dat_o <= next_rdata;
        end
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        control <= `RST_CONTROL;
        reload_value <= `RST_RELOAD;
    end else begin
        if (wr_control) begin
            control <= next_control;
        end
        if (wr_reload) begin
            reload_value <= next_reload;
        end
    end
end

// Prescaler restarts on each step so the divide ratio is exact
always @(posedge clk_i) begin
    if (rst_i) begin
        pre_count <= 15'h0000;
    end else begin
        if (!enable || wr_control) begin
            pre_count <= 15'h0000;
        end else if (src_tick) begin
            if (pre_count >= pre_limit) begin
                pre_count <= 15'h0000;
            end else begin
                pre_count <= pre_count + 15'h0001;
            end
        end
    end
end

// A reload write also loads the counter; bus writes to it are ignored
always @(posedge clk_i) begin
    if (rst_i) begin
        live_count <= `RST_COUNT;
    end else if (wr_reload) begin
        live_count <= next_reload;
    end else begin
        live_count <= next_count;
    end
end

// Snapshot never touches the counter; only edges of the source count
always @(posedge clk_i) begin
    if (rst_i) begin
        snapshot <= `RST_SNAPSHOT;
    end else begin
        if (capture) begin
            snapshot <= live_count;
        end
    end
end

// Mask holds which status bits may drive the interrupt
always @(posedge clk_i) begin
    if (rst_i) begin
        mask <= 2'b00;
    end else if (wr_mask) begin
        mask <= wb_dat_i[1:0];
    end
end

// Timeout bit clears on any clear-register write or a W1C of bit 0
sticky_bit i_st_timeout (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(terminal),
    .clr_i(wr_clear | (wr_status & wb_dat_i[`ST_TIMEOUT])),
    .flag_o(status[`ST_TIMEOUT])
);

sticky_bit i_st_capture (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(capture),
    .clr_i(wr_status & wb_dat_i[`ST_CAPTURE]),
    .flag_o(status[`ST_CAPTURE])
);

// Outputs registered; irq lags its status bit by one cycle
always @(posedge clk_i) begin
    if (rst_i) begin
        irq_o <= 1'b0;
        tick_o <= 1'b0;
    end else begin
        irq_o <= |(status & mask);
        tick_o <= step;
    end
end

endmodule

// One sticky status bit: a new event wins over a clear in the same cycle
// Losing an event to a racing clear would hide it from software for good
module sticky_bit (
    input wire clk_i,
    input wire rst_i,
    input wire set_i,
    input wire clr_i,
    output reg flag_o
);

always @(posedge clk_i) begin
    if (rst_i) begin
        flag_o <= 1'b0;
    end else if (set_i) begin
        flag_o <= 1'b1;
    end else if (clr_i) begin
        flag_o <= 1'b0;
    end
end

endmodule

// Registered copy of a level; a rising edge shows as one cycle high
module rise_detect #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] level_i,
    output wire [WIDTH-1:0] rise_o
);

reg [WIDTH-1:0] prev;

// Reset to the idle low level so no false edge follows reset
always @(posedge clk_i) begin
    if (rst_i) begin
        prev <= {WIDTH{1'b0}};
    end else begin
        prev <= level_i;
    end
end

assign rise_o = level_i & ~prev;

endmodule

// One byte lane of a bus write: enabled lanes take the new data
module byte_lane #(
    parameter WIDTH = 8
) (
    input wire sel_i,
    input wire [WIDTH-1:0] old_i,
    input wire [WIDTH-1:0] new_i,
    output wire [WIDTH-1:0] merged_o
);

assign merged_o = sel_i ? new_i : old_i;

endmodule

// file: tb/event_capture_timer_properties.sv
// Port checker for the event capture timer.
// Assumes a classic Wishbone master that drops cyc for a cycle after ack.
`timescale 1ns/1ps
`include "event_capture_timer_defs.vh"
module event_capture_timer_properties (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire lp_osc_i,
    input wire [17:0] irq_src_i,
    input wire irq_o,
    input wire tick_o
);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd = req && !wb_we_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT: assert property (req |=> wb_ack_o) else $error("ack missing");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_RST_QUIET: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && !tick_o)
        else $error("outputs active in reset");
    AST_RELOAD_WIDTH: assert property (rd && wb_adr_i == `ADR_RELOAD |=> wb_dat_o[31:16] == 16'h0000)
        else $error("reload too wide");
    AST_COUNT_WIDTH: assert property (rd && wb_adr_i == `ADR_COUNT |=> wb_dat_o[31:16] == 16'h0000)
        else $error("count too wide");
    AST_SNAP_WIDTH: assert property (rd && wb_adr_i == `ADR_SNAPSHOT |=> wb_dat_o[31:16] == 16'h0000)
        else $error("snapshot too wide");
    AST_CLEAR_RD: assert property (rd && wb_adr_i == `ADR_IRQ_CLEAR |=> wb_dat_o == 32'h00000000)
        else $error("clear register readable");
    AST_CTL_RSVD: assert property (rd && wb_adr_i == `ADR_CONTROL |=> (wb_dat_o & ~`CTL_WMASK) == 32'h0)
        else $error("reserved control bits set");
    AST_MASK_OFF: assert property (req && wb_we_i && wb_adr_i == `ADR_MASK && wb_sel_i[0]
        && wb_dat_i[1:0] == 2'h0 |=> ##1 !irq_o) else $error("masked irq still high");
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the event capture timer over classic Wishbone.
// Assumes inputs change by non-blocking assignment after rising edges.
`timescale 1ns/1ps
`include "event_capture_timer_defs.vh"
module tb_top;
    reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, lp = 0;
    reg [31:0] adr = 0, wdat = 0, r;
    reg [17:0] src = 0;
    reg [3:0] sel = 0, bsel = 4'hf;
    wire [31:0] rdat;
    wire ack, irq, tick;
    integer n_fail = 0, check_count = 0, ticks = 0, cyc_n = 0, i, t0;
    localparam int CODE[4] = '{0, 4, 8, 15};
    localparam int SPAN[4] = '{64, 320, 1024, 65536};
    event_capture_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .lp_osc_i(lp), .irq_src_i(src), .irq_o(irq), .tick_o(tick));
    initial forever #4 clk_i = ~clk_i;
    task final_report;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Hang guard well above the longest prescaler run
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (tick === 1'b1) ticks <= ticks + 1;
        if (cyc_n == 90000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
    task chk(input [31:0] g, input [31:0] e);
        check_count = check_count + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task bus(input w, input [31:0] a, input [31:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= bsel;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 0; stb <= 0; we <= 0; sel <= 4'h0;
    endtask
    task rd(input [31:0] a, input [31:0] e);
        bus(0, a, 0);
        chk(r, e);
    endtask
    task step(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    initial begin
        step(5);
        rst_i <= 0;
        rd(`ADR_RELOAD, 0);
        rd(`ADR_COUNT, 32'hffff);
        rd(`ADR_CONTROL, 0);
        rd(`ADR_SNAPSHOT, 0);
        rd(32'hffff039c, 0);
        bus(1, `ADR_COUNT, 5);
        bus(1, `ADR_SNAPSHOT, 5);
        rd(`ADR_COUNT, 32'hffff);
        rd(`ADR_SNAPSHOT, 0);
        bus(1, `ADR_CONTROL, 32'hffffffff);
        rd(`ADR_CONTROL, `CTL_WMASK);
        $display("test reset done");
        bus(1, `ADR_CONTROL, 0);
        bsel = 4'h1;
        bus(1, `ADR_RELOAD, 32'habcd);
        bsel = 4'hf;
        rd(`ADR_RELOAD, 32'hcd);
        bus(1, `ADR_RELOAD, 5);
        bus(1, `ADR_MASK, 1);
        bus(1, `ADR_STATUS, 3);
        bus(1, `ADR_CONTROL, 32'hc0);
        step(20);
        chk(irq, 1);
        bus(0, `ADR_COUNT, 0);
        chk(r <= 5, 1);
        bus(1, `ADR_CONTROL, 0);
        bus(1, `ADR_IRQ_CLEAR, 0);
        step(2);
        chk(irq, 0);
        rd(`ADR_STATUS, 0);
        bus(1, `ADR_RELOAD, 3);
        bus(1, `ADR_CONTROL, 32'h80);
        step(10);
        bus(0, `ADR_COUNT, 0);
        chk(r > 32'hff00, 1);
        rd(`ADR_STATUS, 1);
        bus(1, `ADR_CONTROL, 32'h180);
        bus(1, `ADR_RELOAD, 32'hfff0);
        step(30);
        bus(0, `ADR_COUNT, 0);
        chk(r < 32'h40, 1);
        chk(irq, 1);
        bus(1, `ADR_MASK, 0);
        step(2);
        chk(irq, 0);
        $display("test modes done");
        for (i = 0; i < 4; i++) begin
            bus(1, `ADR_CONTROL, 32'h80 | CODE[i]);
            t0 = ticks;
            step(SPAN[i]);
            chk((ticks - t0) * (1 << CODE[i]) <= SPAN[i] + 2 * (1 << CODE[i]), 1);
            chk((ticks - t0 + 1) * (1 << CODE[i]) >= SPAN[i], 1);
        end
        bus(1, `ADR_CONTROL, 32'h280);
        t0 = ticks;
        repeat (5) begin
            lp <= 1;
            step(3);
            lp <= 0;
            step(3);
        end
        step(3);
        chk(ticks - t0, 5);
        $display("test clocking done");
        bus(1, `ADR_CONTROL, 0);
        bus(1, `ADR_STATUS, 3);
        bus(1, `ADR_RELOAD, 32'h1234);
        bus(1, `ADR_CONTROL, 32'h31000);
        src[17] <= 1;
        step(2);
        rd(`ADR_SNAPSHOT, 32'h1234);
        rd(`ADR_STATUS, 2);
        bus(1, `ADR_RELOAD, 32'h4321);
        step(2);
        rd(`ADR_SNAPSHOT, 32'h1234);
        src[17] <= 0;
        bus(1, `ADR_CONTROL, 32'h11000);
        src[17] <= 1;
        step(2);
        rd(`ADR_SNAPSHOT, 32'h1234);
        src <= 0;
        bus(1, `ADR_CONTROL, 32'h23000);
        src[17] <= 1;
        step(2);
        rd(`ADR_SNAPSHOT, 32'h1234);
        src[3] <= 1;
        step(2);
        rd(`ADR_SNAPSHOT, 32'h4321);
        $display("test capture done");
        final_report;
    end
endmodule
bind event_capture_timer event_capture_timer_properties i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .lp_osc_i(lp_osc_i), .irq_src_i(irq_src_i), .irq_o(irq_o), .tick_o(tick_o));
